// ==== inc/timer_pkg.sv ====
// package: register map, field positions, modes and reset values of the timer
package timer_pkg;
  // ------------------------------------------------------------
  // register byte offsets (one aligned word each)
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_COUNT = 8'h00; // timer_count
  localparam logic [7:0] OFF_CMPA = 8'h04; // compare_value_a
  localparam logic [7:0] OFF_CMPB = 8'h08; // compare_value_b
  localparam logic [7:0] OFF_CTRLA = 8'h0c; // timer_ctrl_a
  localparam logic [7:0] OFF_CTRLB = 8'h10; // timer_ctrl_b
  localparam logic [7:0] OFF_FLAG = 8'h14; // timer_flag_reg
  localparam logic [7:0] OFF_MASK = 8'h18; // timer_mask_reg
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRLA_COMA_LSB = 6; // compare a output action, 2 bits
  localparam int CTRLA_COMB_LSB = 4; // compare b output action, 2 bits
  localparam int CTRLA_WGM_LSB = 0; // waveform mode low two bits
  localparam int CTRLB_WGM2_BIT = 3; // waveform mode high bit
  localparam int CTRLB_CS_LSB = 0; // clock select, 3 bits
  localparam int FLAG_OVF_BIT = 0; // overflow_flag
  localparam int FLAG_CMPA_BIT = 1; // compare_flag_a
  localparam int FLAG_CMPB_BIT = 2; // compare_flag_b
  localparam logic [2:0] FLAG_MASK_BITS = 3'h7; // implemented flag bits
  // ------------------------------------------------------------
  // reset values and fixed counts
  // ------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00; // all timer registers
  localparam logic [7:0] BOTTOM_VAL = 8'h00; // bottom condition
  localparam logic [7:0] MAX_VAL = 8'hff; // max condition
  localparam logic [9:0] PRESC_RESET = 10'h000; // prescaler start
  // ------------------------------------------------------------
  // waveform modes and clock selects
  // ------------------------------------------------------------
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_PC_MAX = 3'h1;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] WGM_PC_OCRA = 3'h5;
  localparam logic [2:0] WGM_FAST_OCRA = 3'h7;
  localparam logic [2:0] CS_NONE = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // ------------------------------------------------------------
  // ahb constants
  // ------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage

// ==== verilog/tick_gen.sv ====
// timer tick source: prescaler, external input synchroniser and edge select
`timescale 1ns/1ps
module tick_gen
  import timer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] clockSel, // clock_select_field
  input wire logic extCountIn, // ext_count_input, asynchronous pin
  output logic timerTick // one-cycle timer_tick pulse
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [9:0] presc; // free-running prescaler
    logic sync1; // first synchroniser stage
    logic sync2; // second synchroniser stage
    logic extPrev; // previous synchronised level
  } tick_state_t;
  tick_state_t st_r, st_nxt;
  logic extRise, extFall, prescHit;

  // next-state: prescaler and synchroniser chain
  always_comb begin
    st_nxt = st_r;
    st_nxt.presc = st_r.presc + 10'h001;
    st_nxt.sync1 = extCountIn;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.extPrev = st_r.sync2;
  end

  // edge detect only on the second stage
  assign extRise = st_r.sync2 & ~st_r.extPrev;
  assign extFall = ~st_r.sync2 & st_r.extPrev;

  // source and edge choice, none when select is zero
  always_comb begin
    unique case (clockSel)
      CS_NONE: prescHit = 1'b0;
      CS_DIV1: prescHit = 1'b1;
      CS_DIV8: prescHit = (st_r.presc[2:0] == 3'h7);
      CS_DIV64: prescHit = (st_r.presc[5:0] == 6'h3f);
      CS_DIV256: prescHit = (st_r.presc[7:0] == 8'hff);
      CS_DIV1024: prescHit = (st_r.presc == 10'h3ff);
      CS_EXT_FALL: prescHit = extFall;
      CS_EXT_RISE: prescHit = extRise;
    endcase
  end
  assign timerTick = prescHit;

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '{PRESC_RESET, 1'b0, 1'b0, 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  a_no_tick_stop: assert property (@(posedge mclk) disable iff (rst)
    (clockSel == CS_NONE) |-> !timerTick)
    else $error("tick while clock select is zero");
endmodule // tick_gen

// ==== verilog/timer0_counter_unit.sv ====
// timer0_counter_unit: 8-bit timer/counter with ahb-lite register access
`timescale 1ns/1ps
module timer0_counter_unit
  import timer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic extCountIn, // ext_count_input pin
  input wire logic [1:0] intAck, // serviced: bit0 compare a, bit1 compare b
  input wire logic ovfAck, // overflow interrupt serviced
  output logic [2:0] irqReq, // masked requests: ovf, cmpa, cmpb
  output logic compareOutA, // compare_out_a
  output logic compareOutB // compare_out_b
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] count; // timer_count
    logic [7:0] cmpA; // active compare_value_a
    logic [7:0] cmpB; // active compare_value_b
    logic [7:0] bufA; // software copy of compare a
    logic [7:0] bufB; // software copy of compare b
    logic [7:0] ctrlA; // timer_ctrl_a
    logic [7:0] ctrlB; // timer_ctrl_b
    logic [2:0] flags; // timer_flag_reg
    logic [2:0] mask; // timer_mask_reg
    logic down; // current count direction
    logic blockMatch; // count write blocks next tick match
    logic outA; // compare a output state
    logic outB; // compare b output state
    logic wrPend; // data phase of a write
    logic [7:0] wrAddr; // latched write address
    logic [31:0] rdata; // read data
  } timer_state_t;
  timer_state_t st_r, st_nxt;

  logic timerTick;
  logic [2:0] wgm;
  logic [7:0] topVal, wdata8;
  logic isPwm, isPc, atTop, atBottom, atMax, eqA, eqB, addrPhase;
  logic wrCount, wrFlag;
  logic [2:0] setEvt; // flags being set this cycle, beat any clear

  // ------------------------------------------------------------
  // tick source
  // ------------------------------------------------------------
  tick_gen u_tick (
    .mclk(mclk),
    .rst(rst),
    .clockSel(st_r.ctrlB[CTRLB_CS_LSB +: 3]),
    .extCountIn(extCountIn),
    .timerTick(timerTick)
  );

  // read data for one register offset
  function automatic logic [31:0] readReg(input logic [7:0] a, input timer_state_t s);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      OFF_COUNT: v[7:0] = s.count;
      OFF_CMPA: v[7:0] = s.bufA;
      OFF_CMPB: v[7:0] = s.bufB;
      OFF_CTRLA: v[7:0] = s.ctrlA;
      OFF_CTRLB: v[7:0] = s.ctrlB;
      OFF_FLAG: v[2:0] = s.flags;
      OFF_MASK: v[2:0] = s.mask;
      default: v = 32'h0000_0000; // unmapped reads zero
    endcase
    return v;
  endfunction

  // ------------------------------------------------------------
  // decode of mode, top and conditions
  // ------------------------------------------------------------
  always_comb begin
    wgm = {st_r.ctrlB[CTRLB_WGM2_BIT], st_r.ctrlA[CTRLA_WGM_LSB +: 2]};
    isPwm = (wgm[1:0] != 2'h0) && (wgm != WGM_CTC) && (wgm != 3'h6);
    isPc = (wgm == WGM_PC_MAX) || (wgm == WGM_PC_OCRA);
    // top fixed or from compare a
    topVal = (wgm == WGM_CTC || wgm == WGM_PC_OCRA || wgm == WGM_FAST_OCRA)
      ? st_r.cmpA : MAX_VAL;
    atTop = (st_r.count == topVal);
    atBottom = (st_r.count == BOTTOM_VAL);
    atMax = (st_r.count == MAX_VAL);
    eqA = (st_r.count == st_r.cmpA);
    eqB = (st_r.count == st_r.cmpB);
    addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    wdata8 = hwdata[7:0];
    wrCount = st_r.wrPend && (st_r.wrAddr == OFF_COUNT);
    wrFlag = st_r.wrPend && (st_r.wrAddr == OFF_FLAG);
  end

  // ------------------------------------------------------------
  // next state: counter, compare, flags and bus
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    setEvt = 3'h0;
    // bus address phase
    st_nxt.wrPend = addrPhase && hwrite;
    st_nxt.wrAddr = {haddr[7:2], 2'b00};
    if (addrPhase && !hwrite) begin
      st_nxt.rdata = readReg({haddr[7:2], 2'b00}, st_r);
    end
    // counter on tick
    if (timerTick) begin
      st_nxt.blockMatch = 1'b0;
      // overflow bit rebuilt below, so a fresh set is visible
      st_nxt.flags[FLAG_OVF_BIT] = 1'b0;
      // compare flags on the tick after the count reached the value
      if (eqA && !st_r.blockMatch) begin
        st_nxt.flags[FLAG_CMPA_BIT] = 1'b1;
        setEvt[FLAG_CMPA_BIT] = 1'b1;
      end
      if (eqB && !st_r.blockMatch) begin
        st_nxt.flags[FLAG_CMPB_BIT] = 1'b1;
        setEvt[FLAG_CMPB_BIT] = 1'b1;
      end
      if (isPc) begin
        // dual slope: turn at top and bottom
        if (st_r.down) begin
          st_nxt.count = st_r.count - 8'h01;
          if (st_r.count == 8'h01) begin
            st_nxt.down = 1'b0;
          end
        end else begin
          st_nxt.count = st_r.count + 8'h01;
          if (st_r.count + 8'h01 == topVal || atTop) begin
            st_nxt.down = 1'b1;
          end
          if (atTop) begin
            st_nxt.count = st_r.count - 8'h01;
          end
        end
        if (atBottom && st_r.down == 1'b0) begin
          st_nxt.flags[FLAG_OVF_BIT] = 1'b1;
        end
        if (atTop) begin
          st_nxt.cmpA = st_r.bufA;
          st_nxt.cmpB = st_r.bufB;
        end
      end else if (atTop && wgm != WGM_NORMAL) begin
        st_nxt.count = BOTTOM_VAL;
        st_nxt.down = 1'b0;
        if (isPwm) begin
          st_nxt.flags[FLAG_OVF_BIT] = 1'b1;
          st_nxt.cmpA = st_r.bufA;
          st_nxt.cmpB = st_r.bufB;
        end else if (atMax) begin
          st_nxt.flags[FLAG_OVF_BIT] = 1'b1;
        end
      end else begin
        st_nxt.count = st_r.count + 8'h01;
        st_nxt.down = 1'b0;
        if (atMax) begin
          st_nxt.flags[FLAG_OVF_BIT] = 1'b1;
        end
      end
      // waveform generator on match
      if (eqA && !st_r.blockMatch) begin
        unique case (st_r.ctrlA[CTRLA_COMA_LSB +: 2])
          2'h0: st_nxt.outA = st_r.outA;
          2'h1: st_nxt.outA = ~st_r.outA;
          2'h2: st_nxt.outA = isPc ? ~st_r.down : 1'b0;
          2'h3: st_nxt.outA = isPc ? st_r.down : 1'b1;
        endcase
      end
      if (eqB && !st_r.blockMatch) begin
        unique case (st_r.ctrlA[CTRLA_COMB_LSB +: 2])
          2'h0: st_nxt.outB = st_r.outB;
          2'h1: st_nxt.outB = ~st_r.outB;
          2'h2: st_nxt.outB = isPc ? ~st_r.down : 1'b0;
          2'h3: st_nxt.outB = isPc ? st_r.down : 1'b1;
        endcase
      end
      if (isPwm && !isPc && atTop) begin
        if (st_r.ctrlA[CTRLA_COMA_LSB + 1]) begin
          st_nxt.outA = ~st_r.ctrlA[CTRLA_COMA_LSB];
        end
        if (st_r.ctrlA[CTRLA_COMB_LSB + 1]) begin
          st_nxt.outB = ~st_r.ctrlA[CTRLA_COMB_LSB];
        end
      end
    end
    // overflow set event, then the old flag merged back
    setEvt[FLAG_OVF_BIT] = timerTick && st_nxt.flags[FLAG_OVF_BIT];
    st_nxt.flags[FLAG_OVF_BIT] = st_nxt.flags[FLAG_OVF_BIT] | st_r.flags[FLAG_OVF_BIT];
    // interrupt service clears, a setting event wins
    if (ovfAck && !setEvt[FLAG_OVF_BIT]) begin
      st_nxt.flags[FLAG_OVF_BIT] = 1'b0;
    end
    if (intAck[0] && !setEvt[FLAG_CMPA_BIT]) begin
      st_nxt.flags[FLAG_CMPA_BIT] = 1'b0;
    end
    if (intAck[1] && !setEvt[FLAG_CMPB_BIT]) begin
      st_nxt.flags[FLAG_CMPB_BIT] = 1'b0;
    end
    // bus data phase writes
    if (st_r.wrPend) begin
      unique case (st_r.wrAddr)
        OFF_COUNT: begin
          st_nxt.count = wdata8;
          st_nxt.blockMatch = 1'b1;
        end
        OFF_CMPA: begin
          st_nxt.bufA = wdata8;
          if (!isPwm) begin
            st_nxt.cmpA = wdata8;
          end
        end
        OFF_CMPB: begin
          st_nxt.bufB = wdata8;
          if (!isPwm) begin
            st_nxt.cmpB = wdata8;
          end
        end
        OFF_CTRLA: st_nxt.ctrlA = wdata8;
        OFF_CTRLB: st_nxt.ctrlB = wdata8 & 8'h0f;
        OFF_FLAG: begin
          // write one clears, except a flag being set now
          st_nxt.flags = st_nxt.flags & ~(wdata8[2:0] & ~setEvt);
        end
        OFF_MASK: st_nxt.mask = wdata8[2:0] & FLAG_MASK_BITS;
        default: st_nxt.count = st_nxt.count; // unmapped write ignored
      endcase
    end
  end

  // state register, everything zero at reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign hrdata = st_r.rdata;
  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0; // always okay
  assign irqReq = st_r.flags & st_r.mask;
  assign compareOutA = st_r.outA;
  assign compareOutB = st_r.outB;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_match_a;
    timerTick && eqA && !st_r.blockMatch && !wrCount;
  endsequence
  sequence s_no_tick;
    !timerTick && !st_r.wrPend;
  endsequence

  a_irq_masked: assert property (@(posedge mclk) disable iff (rst)
    irqReq == (st_r.flags & st_r.mask))
    else $error("interrupt not gated by mask");
  a_stop_hold: assert property (@(posedge mclk) disable iff (rst)
    (st_r.ctrlB[2:0] == CS_NONE && !st_r.wrPend) |=> $stable(st_r.count))
    else $error("counter moved while stopped");
  a_write_wins: assert property (@(posedge mclk) disable iff (rst)
    wrCount |=> st_r.count == $past(hwdata[7:0]))
    else $error("count write lost");
  a_normal_up: assert property (@(posedge mclk) disable iff (rst)
    (timerTick && wgm == WGM_NORMAL && !st_r.wrPend) |=> st_r.count == $past(st_r.count) + 8'h01)
    else $error("normal mode did not count up");
  a_ovf_wrap: assert property (@(posedge mclk) disable iff (rst)
    (timerTick && wgm == WGM_NORMAL && atMax && !ovfAck && !wrFlag) |=> st_r.flags[0])
    else $error("overflow flag missed at wrap");
  a_ctc_clear: assert property (@(posedge mclk) disable iff (rst)
    (timerTick && wgm == WGM_CTC && eqA && !st_r.wrPend) |=> st_r.count == BOTTOM_VAL)
    else $error("ctc did not clear on match");
  a_flag_a_late: assert property (@(posedge mclk) disable iff (rst)
    s_no_tick |=> !$rose(st_r.flags[1]))
    else $error("compare flag set before next tick");
  a_direct_cmp: assert property (@(posedge mclk) disable iff (rst)
    (st_r.wrPend && st_r.wrAddr == OFF_CMPA && !isPwm) |=> st_r.cmpA == $past(hwdata[7:0]))
    else $error("compare a not written directly");
  a_flag_a_set: assert property (@(posedge mclk) disable iff (rst)
    s_match_a |=> st_r.flags[1])
    else $error("compare a flag not set");
endmodule // timer0_counter_unit

// ==== testbench/timer0_counter_unit_tb.sv ====
// testbench: self-checking random and corner tests of the timer block
`timescale 1ns/1ps
module timer0_counter_unit_tb
  import timer_pkg::*;
;
  // ------------------------------------------------------------
  // signals and counters
  // ------------------------------------------------------------
  logic mclk = 1'b0; // 250 mhz system clock
  logic rst = 1'b1; // sync reset, active high
  logic hsel = 1'b0, hwrite = 1'b0, extCountIn = 1'b0, ovfAck = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [1:0] intAck = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, compareOutA, compareOutB;
  logic [2:0] irqReq;
  int badCount = 0; // mismatches
  int nChecks = 0; // comparisons made
  int cycles = 0; // timeout counter
  logic [7:0] v, top, cnt;
  int n;

  timer0_counter_unit u_dut (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .extCountIn(extCountIn), .intAck(intAck), .ovfAck(ovfAck),
    .irqReq(irqReq), .compareOutA(compareOutA), .compareOutB(compareOutB)
  );

  // clock generator, 4 ns period
  initial begin
    forever #2 mclk = ~mclk;
  end

  // ------------------------------------------------------------
  // bench tasks
  // ------------------------------------------------------------
  // compare and report
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic testDone();
    if (badCount == 0 && nChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one ahb-lite single transfer, entered just after a rising edge
  task automatic busXfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                         output logic [31:0] rdv);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] dummy;
    busXfer(1'b1, a, {$urandom() & 32'hffffff00} | {24'h0, d}, dummy);
  endtask

  // read a register and compare with a byte
  task automatic rdChk(input string what, input logic [7:0] a, input logic [7:0] exp);
    busXfer(1'b0, a, 32'h0, rd);
    check(what, rd, {24'h0, exp});
  endtask

  // k full pulses on the external count pin, each slow enough to settle
  task automatic extTicks(input int k);
    repeat (k) begin
      extCountIn <= 1'b1;
      repeat (6) @(posedge mclk);
      extCountIn <= 1'b0;
      repeat (6) @(posedge mclk);
    end
  endtask

  // mode field split across both control registers, outputs set to toggle
  task automatic setMode(input logic [2:0] wgm, input logic [2:0] cs);
    wr(OFF_CTRLA, {4'b0101, 2'b00, wgm[1:0]});
    wr(OFF_CTRLB, {4'h0, wgm[2], cs});
  endtask

  // expected next count for one tick in normal or clear-on-match mode
  function automatic logic [7:0] nextCount(logic [2:0] wgm, logic [7:0] c, logic [7:0] t);
    if (wgm == WGM_CTC && c == t) begin
      return BOTTOM_VAL;
    end
    return c + 8'h01;
  endfunction

  // cut a hang short
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      badCount++;
      testDone();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(12));
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // reset values, unmapped place included
    for (int a = 0; a <= 8'h1c; a += 4) begin
      rdChk("reset value", a[7:0], REG_RESET);
    end
    // register access with random data, stopped normal mode
    for (int i = 0; i < 4; i++) begin
      v = $urandom();
      wr(OFF_COUNT, v);
      rdChk("count rw", OFF_COUNT, v);
      wr(OFF_CMPA, v ^ 8'h5a);
      rdChk("cmp a rw", OFF_CMPA, v ^ 8'h5a);
      wr(OFF_CMPB, ~v);
      rdChk("cmp b rw", OFF_CMPB, ~v);
    end
    wr(OFF_MASK, 8'hff);
    rdChk("mask rw", OFF_MASK, 8'h07);
    wr(OFF_CTRLB, 8'hf8);
    rdChk("ctrl b rw", OFF_CTRLB, 8'h08);
    wr(8'h1c, 8'h55);
    rdChk("unmapped", 8'h1c, 8'h00);
    wr(OFF_MASK, 8'h00);
    // external ticks on both edges, compare flags one tick after match
    for (int cs = CS_EXT_FALL; cs <= CS_EXT_RISE; cs++) begin
      v = $urandom_range(0, 8'hf0);
      setMode(WGM_NORMAL, CS_NONE);
      wr(OFF_COUNT, v);
      wr(OFF_CMPA, v + 8'h02);
      wr(OFF_CMPB, v + 8'h03);
      wr(OFF_FLAG, 8'h07);
      wr(OFF_CTRLB, {5'h0, cs[2:0]});
      extTicks(2);
      rdChk("count after ticks", OFF_COUNT, v + 8'h02);
      rdChk("flag at match", OFF_FLAG, 8'h00);
      extTicks(1);
      rdChk("flag a next tick", OFF_FLAG, 8'h02);
      extTicks(1);
      rdChk("flag b next tick", OFF_FLAG, 8'h06);
      check("out a toggle", {31'h0, compareOutA}, {31'h0, cs == CS_EXT_FALL});
      check("out b toggle", {31'h0, compareOutB}, {31'h0, cs == CS_EXT_FALL});
      check("irq masked", {29'h0, irqReq}, 32'h0);
      wr(OFF_MASK, 8'h06);
      @(posedge mclk);
      check("irq unmasked", {29'h0, irqReq}, 32'h6);
      intAck <= 2'b01;
      @(posedge mclk);
      intAck <= 2'b00;
      wr(OFF_FLAG, 8'h04);
      rdChk("flags cleared", OFF_FLAG, 8'h00);
      check("irq cleared", {29'h0, irqReq}, 32'h0);
      wr(OFF_MASK, 8'h00);
    end
    // overflow at the wrap to bottom in normal mode
    setMode(WGM_NORMAL, CS_EXT_RISE);
    wr(OFF_COUNT, 8'hfe);
    wr(OFF_FLAG, 8'h07);
    extTicks(1);
    busXfer(1'b0, OFF_FLAG, 32'h0, rd);
    check("ovf before wrap", rd & 32'h1, 32'h0);
    extTicks(1);
    rdChk("count wrapped", OFF_COUNT, BOTTOM_VAL);
    busXfer(1'b0, OFF_FLAG, 32'h0, rd);
    check("ovf set", rd & 32'h1, 32'h1);
    check("ovf irq masked", {31'h0, irqReq[0]}, 32'h0);
    wr(OFF_MASK, 8'h01);
    @(posedge mclk);
    check("ovf irq", {31'h0, irqReq[0]}, 32'h1);
    ovfAck <= 1'b1;
    @(posedge mclk);
    ovfAck <= 1'b0;
    @(posedge mclk);
    check("ovf ack", {31'h0, irqReq[0]}, 32'h0);
    wr(OFF_MASK, 8'h00);
    // clear on match: random top, random tick counts
    for (int i = 0; i < 3; i++) begin
      top = $urandom_range(3, 9);
      n = $urandom_range(top, 2 * top + 3);
      setMode(WGM_CTC, CS_NONE);
      wr(OFF_CMPA, top);
      wr(OFF_COUNT, 8'h00);
      wr(OFF_CTRLB, {5'h0, CS_EXT_RISE});
      cnt = 8'h00;
      for (int k = 0; k < n; k++) begin
        cnt = nextCount(WGM_CTC, cnt, top);
      end
      extTicks(n);
      rdChk("ctc count", OFF_COUNT, cnt);
    end
    // every prescaler ratio advances the count, stop freezes it
    setMode(WGM_NORMAL, CS_NONE);
    for (int cs = CS_DIV1; cs <= CS_DIV1024; cs++) begin
      n = (cs == 1) ? 1 : (cs == 2) ? 8 : (cs == 3) ? 64 : (cs == 4) ? 256 : 1024;
      wr(OFF_COUNT, 8'h00);
      wr(OFF_CTRLB, {5'h0, cs[2:0]});
      repeat (4 * n) @(posedge mclk);
      wr(OFF_CTRLB, {5'h0, CS_NONE});
      busXfer(1'b0, OFF_COUNT, 32'h0, rd);
      check("prescaled count", 32'((rd >= 3) && (rd <= 9)), 32'h1);
      v = rd[7:0];
      repeat (50) @(posedge mclk);
      rdChk("stopped count", OFF_COUNT, v);
    end
    // pwm mode: software sees its buffered compare value
    setMode(WGM_FAST_MAX, CS_NONE);
    wr(OFF_CMPA, 8'h3c);
    rdChk("pwm buffer", OFF_CMPA, 8'h3c);
    setMode(WGM_NORMAL, CS_NONE);
    // cpu write beats counting while ticking every cycle
    wr(OFF_CTRLB, {5'h0, CS_DIV1});
    v = $urandom_range(8'h10, 8'he0);
    wr(OFF_COUNT, v);
    wr(OFF_CTRLB, {5'h0, CS_NONE});
    busXfer(1'b0, OFF_COUNT, 32'h0, rd);
    check("write priority", 32'((rd[7:0] - v) < 8'h04), 32'h1);
    testDone();
  end
endmodule // timer0_counter_unit_tb
